// >>> rtl/wdc_pkg.sv
// Package of constants and types for the watchdog control unit
package wdc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDC_CTRL_IDX   = 8'haa;   // Control register index
  localparam logic [9:0] WDC_CTRL_ADDR  = 10'h2a8; // Index times four
  localparam logic [9:0] WDC_TA_ADDR    = 10'h300; // Unlock key register
  localparam logic [9:0] WDC_CFG_ADDR   = 10'h304; // Config enable / mode
  localparam logic [9:0] WDC_STAT_ADDR  = 10'h308; // Sticky event status
  localparam logic [9:0] WDC_MASK_ADDR  = 10'h30c; // Interrupt mask
  localparam logic [9:0] WDC_CNT_ADDR   = 10'h310; // Live counter value
  localparam int         WDC_ADDR_W     = 10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int WDC_RUN_BIT  = 7;
  localparam int WDC_CLR_BIT  = 6;
  localparam int WDC_TOF_BIT  = 5;
  localparam int WDC_LPR_BIT  = 4;
  localparam int WDC_RSTF_BIT = 3;
  localparam int WDC_PS_HI    = 2;
  localparam int WDC_PS_LO    = 0;
  localparam logic [2:0] WDC_PS_POR     = 3'h7;   // Largest division
  localparam logic [3:0] WDC_CFG_GPT    = 4'hf;   // General timer config
  localparam logic [3:0] WDC_CFG_POR    = 4'hf;

  // Unlock key: two writes, with no other write between them
  localparam logic [7:0] WDC_KEY1       = 8'haa;
  localparam logic [7:0] WDC_KEY2       = 8'h55;

  // Status bits
  localparam int WDC_EV_TOF = 0;  // Counter overflow
  localparam int WDC_EV_RST = 1;  // Watchdog reset issued
  localparam int WDC_EV_W   = 2;

  // Prescaler ratios 1,4,8,16,32,64,128,256 as shift amounts
  localparam int WDC_PRE_W = 8;

  typedef enum logic [1:0] {TA_IDLE, TA_HALF, TA_OPEN} wdc_ta_t;
endpackage : wdc_pkg

// >>> rtl/wdc_prescaler.sv
// Prescaler that turns the system clock into counting ticks
`timescale 1ns/1ps
`default_nettype none
module wdc_prescaler
  import wdc_pkg::*;
(
  input  wire logic       clk,    // System clock
  input  wire logic       rst,    // Asynchronous reset
  input  wire logic       en,     // Counting allowed
  input  wire logic [2:0] sel,    // Ratio select
  output logic            tick    // One-cycle tick
);
  logic [WDC_PRE_W-1:0] div_r;

  // Ratio mask: select 0 passes every cycle, 7 one in 256
  function automatic logic [WDC_PRE_W-1:0] ratio_mask(input logic [2:0] s);
    ratio_mask = (s == 3'h0) ? 8'h00 : 8'(8'hff >> (3'h7 - s));
  endfunction

  // Free divider, held while stopped so ratios restart cleanly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
    end else if (en) begin
      div_r <= div_r + 8'h01;
    end
  end

  assign tick = en && ((div_r & ratio_mask(sel)) == ratio_mask(sel)); // [RQ8]
endmodule : wdc_prescaler
`default_nettype wire

// >>> rtl/wdc_unlock.sv
// Timed-access unlock sequencer guarding the control register
`timescale 1ns/1ps
`default_nettype none
module wdc_unlock
  import wdc_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Asynchronous reset
  input  wire logic       key_we,   // Write to unlock register
  input  wire logic [7:0] key,      // Written key byte
  input  wire logic       other_we, // Any other accepted write
  output logic            open      // Next control write allowed
);
  wdc_ta_t st_r;

  // Key pair opens one write; any other write closes again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= TA_IDLE;
    end else begin
      case (st_r)
        TA_IDLE: st_r <= (key_we && key == WDC_KEY1) ? TA_HALF : TA_IDLE;
        TA_HALF: begin
          if (key_we && key == WDC_KEY2) st_r <= TA_OPEN;
          else if (key_we || other_we)   st_r <= TA_IDLE;
        end
        TA_OPEN: if (key_we || other_we) st_r <= TA_IDLE; // [RQ11]
        default: st_r <= TA_IDLE;
      endcase
    end
  end

  assign open = (st_r == TA_OPEN);
endmodule : wdc_unlock
`default_nettype wire

// >>> rtl/wdc_top.sv
// Watchdog control unit: protected control register, counter and flags
// Notes on behaviour
// [RQ1] Run bit starts counter only when config enable bits are all ones.
// [RQ2] Writing one to clear bit zeroes the counter; zero does nothing.
// [RQ3] Clear bit reads one until the counter clear has completed.
// [RQ4] Overflow sets time-out flag; it stays until software clears it.
// [RQ5] Low-power-run bit chooses stop or keep counting in idle/power-down; the code does so in timer config only, reset config always stops.
// [RQ6] Watchdog time-out reset sets reset flag; software should clear it.
// [RQ7] Power-on clears reset flag, watchdog reset sets it, others keep it.
// [RQ8] Three-bit prescale select divides 1/1 to 1/256, default largest.
// [RQ9] Power-on sets prescale field; other resets keep it.
// [RQ10] With divided system clock, power-down exit should use wake-up timer.
// [RQ11] Control writes need the unlock sequence immediately before.
// [RQ12] In reset configuration an overflow resets device, sets reset flag.
// [RQ13] Counter steps per prescaled tick; wrap from maximum sets flag.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module wdc_top
  import wdc_pkg::*;
#(
  parameter int CNT_W = 6                   // Watchdog counter width
)(
  input  wire logic        CLK_SYS,         // 40 MHz clock
  input  wire logic        RST,             // Async reset, active high
  input  wire logic        POR_PULSE,       // Power-on reset seen, 1 cycle
  input  wire logic        LOWPOWER,        // Idle or power-down active
  input  wire logic        WB_CYC_I,        // Wishbone cycle
  input  wire logic        WB_STB_I,        // Wishbone strobe
  input  wire logic        WB_WE_I,         // Wishbone write
  input  wire logic [9:0]  WB_ADR_I,        // Byte address
  input  wire logic [3:0]  WB_SEL_I,        // Byte selects
  input  wire logic [31:0] WB_DAT_I,        // Write data
  output logic [31:0]      WB_DAT_O,        // Read data
  output logic             WB_ACK_O,        // Acknowledge
  output logic             WB_ERR_O,        // Unmapped address
  output logic             WDT_RESET_REQ,   // Device reset request pulse
  output logic             IRQ              // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic             run_r, lpr_r, tof_r, rstf_r, clr_r;
  logic [2:0]       ps_r;
  logic [3:0]       cfg_r;
  logic [CNT_W-1:0] cnt_r;
  logic [WDC_EV_W-1:0] stat_r, mask_r;
  logic             ack_nxt, req, wr, rd, b0, open, tick, ovf;
  logic             ctrl_wr, gpt, counting, hit;
  logic [7:0]       ctrl_rd;
  logic [WDC_EV_W-1:0] ev;

  // ----------------------------------------------------------------
  // Bus decode: one wait cycle, answer one edge after request
  // ----------------------------------------------------------------
  assign req  = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign hit  = (WB_ADR_I == WDC_CTRL_ADDR) || (WB_ADR_I == WDC_TA_ADDR) ||
                (WB_ADR_I == WDC_CFG_ADDR)  || (WB_ADR_I == WDC_STAT_ADDR) ||
                (WB_ADR_I == WDC_MASK_ADDR) || (WB_ADR_I == WDC_CNT_ADDR);
  assign wr   = req && hit && WB_WE_I;
  assign rd   = req && hit && !WB_WE_I;
  assign b0   = WB_SEL_I[0];
  assign ctrl_wr = wr && b0 && (WB_ADR_I == WDC_CTRL_ADDR) && open; // [RQ11]
  assign gpt  = (cfg_r == WDC_CFG_GPT);
  // Counting needs run (timer mode) or is on in reset mode while LOWPOWER is low
  assign counting = (gpt ? run_r : 1'b1) &&                      // [RQ1]
                    (!LOWPOWER || (gpt && lpr_r));               // [RQ5]
  assign ovf  = tick && (&cnt_r) && !clr_r;                      // [RQ13]
  assign ev   = {ovf && !gpt, ovf};

  wdc_unlock u_unlock (
    .clk      (CLK_SYS),
    .rst      (RST),
    .key_we   (wr && b0 && WB_ADR_I == WDC_TA_ADDR),
    .key      (WB_DAT_I[7:0]),
    .other_we (wr && WB_ADR_I != WDC_TA_ADDR),
    .open     (open)
  );

  wdc_prescaler u_pre (
    .clk  (CLK_SYS),
    .rst  (RST),
    .en   (counting),
    .sel  (ps_r),
    .tick (tick)
  );

  // Acknowledge and error, each one cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && hit;
      WB_ERR_O <= req && !hit;
    end
  end

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  // Ordinary reset keeps prescale; only power-on loads the maximum.
  // RST is a block reset, so these bits are not on it.
  always_ff @(posedge CLK_SYS) begin
    if (POR_PULSE) begin
      ps_r   <= WDC_PS_POR;                                      // [RQ9]
      rstf_r <= 1'b0;                                            // [RQ7]
      cfg_r  <= WDC_CFG_POR;
    end else begin
      if (ctrl_wr) ps_r <= WB_DAT_I[WDC_PS_HI:WDC_PS_LO];        // [RQ8]
      // Hardware set wins over a software clear in the same cycle
      if (ev[WDC_EV_RST]) rstf_r <= 1'b1;                        // [RQ6] [RQ12]
      else if (ctrl_wr) rstf_r <= WB_DAT_I[WDC_RSTF_BIT];        // [RQ7]
      if (wr && b0 && WB_ADR_I == WDC_CFG_ADDR) cfg_r <= WB_DAT_I[3:0];
    end
  end

  // Run, low-power-run, time-out flag
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_r <= 1'b0;
      lpr_r <= 1'b0;
      tof_r <= 1'b0;
    end else begin
      if (ctrl_wr) run_r <= WB_DAT_I[WDC_RUN_BIT];               // [RQ1]
      if (ctrl_wr) lpr_r <= WB_DAT_I[WDC_LPR_BIT];               // [RQ5]
      if (ovf) tof_r <= 1'b1;                                    // [RQ4]
      else if (ctrl_wr) tof_r <= WB_DAT_I[WDC_TOF_BIT];
    end
  end

  // Clear request pending until the counter is zeroed next cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      clr_r <= 1'b0;
    end else if (ctrl_wr && WB_DAT_I[WDC_CLR_BIT]) begin
      clr_r <= 1'b1;                                             // [RQ2]
    end else begin
      clr_r <= 1'b0;                                             // [RQ3]
    end
  end

  // Watchdog counter
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cnt_r <= '0;
    end else if (clr_r) begin
      cnt_r <= '0;                                               // [RQ2]
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;                                     // [RQ13]
    end
  end

  // Device reset request when overflowing in reset configuration
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WDT_RESET_REQ <= 1'b0;
    end else begin
      WDT_RESET_REQ <= ev[WDC_EV_RST];                           // [RQ12]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stat_r <= '0;
      mask_r <= '0;
      IRQ    <= 1'b0;
    end else begin
      // Set beats write-one-to-clear
      if (wr && b0 && WB_ADR_I == WDC_STAT_ADDR)
        stat_r <= (stat_r & ~WB_DAT_I[WDC_EV_W-1:0]) | ev;
      else
        stat_r <= stat_r | ev;
      if (wr && b0 && WB_ADR_I == WDC_MASK_ADDR)
        mask_r <= WB_DAT_I[WDC_EV_W-1:0];
      IRQ <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign ctrl_rd = {run_r, clr_r, tof_r, lpr_r, rstf_r, ps_r};   // [RQ3]

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (rd) begin
      case (WB_ADR_I)
        WDC_CTRL_ADDR: WB_DAT_O <= {24'h00_0000, ctrl_rd};
        WDC_CFG_ADDR:  WB_DAT_O <= {28'h000_0000, cfg_r};
        WDC_STAT_ADDR: WB_DAT_O <= {30'h0, stat_r};
        WDC_MASK_ADDR: WB_DAT_O <= {30'h0, mask_r};
        WDC_CNT_ADDR:  WB_DAT_O <= 32'(cnt_r);
        default:       WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_locked_write: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr && b0 && WB_ADR_I == WDC_CTRL_ADDR && !open && !ovf && !POR_PULSE)
      |=> $stable(run_r)) else $error("locked write changed run"); // [RQ11]
  a_clear_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    ctrl_wr && WB_DAT_I[WDC_CLR_BIT] |=> ##1 (cnt_r == '0))
    else $error("clear did not zero counter"); // [RQ2]
  a_clear_read: assert property (@(posedge CLK_SYS) disable iff (RST)
    clr_r |=> !clr_r || $past(ctrl_wr))
    else $error("clear stuck"); // [RQ3]
  a_tof_set: assert property (@(posedge CLK_SYS) disable iff (RST)
    ovf |=> tof_r) else $error("timeout flag not set"); // [RQ4]
  a_stop_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
    (LOWPOWER && !lpr_r && !clr_r) |=> $stable(cnt_r))
    else $error("counter ran in low power"); // [RQ5]
  a_run_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
    (gpt && !run_r && !clr_r) |=> $stable(cnt_r))
    else $error("counter ran while disabled"); // [RQ1]
  a_rst_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ev[WDC_EV_RST] && !POR_PULSE) |=> (rstf_r && WDT_RESET_REQ))
    else $error("reset flag not set"); // [RQ12]
  a_por_prescale: assert property (@(posedge CLK_SYS) disable iff (RST)
    POR_PULSE |=> (ps_r == WDC_PS_POR && !rstf_r))
    else $error("power-on values wrong"); // [RQ9]
  a_irq_level: assert property (@(posedge CLK_SYS) disable iff (RST)
    |(stat_r & mask_r) |=> IRQ) else $error("irq missing");

  // Bus answer: exactly one cycle after a request, one cycle wide
  a_ack_timing: assert property (@(posedge CLK_SYS) disable iff (RST)
    (req && hit) |=> WB_ACK_O)
    else $error("ack not given one cycle after request");
  a_ack_pulse: assert property (@(posedge CLK_SYS) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (@(posedge CLK_SYS) disable iff (RST)
    (req && !hit) |=> (WB_ERR_O && !WB_ACK_O))
    else $error("unmapped access not refused");

  // Control read shows the live clear-in-progress bit
  a_ctrl_rdata: assert property (@(posedge CLK_SYS) disable iff (RST)
    (rd && WB_ADR_I == WDC_CTRL_ADDR) |=> WB_DAT_O[7:0] == $past(ctrl_rd))
    else $error("control read data wrong"); // [RQ3]
  a_clr_pending: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ctrl_wr && WB_DAT_I[WDC_CLR_BIT]) |=> clr_r)
    else $error("clear not shown as pending"); // [RQ3]
  a_clr_zeroes: assert property (@(posedge CLK_SYS) disable iff (RST)
    clr_r |=> (cnt_r == '0))
    else $error("pending clear left counter"); // [RQ2]

  // Counter steps once per tick, wrapping at its width
  a_cnt_step: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tick && !clr_r) |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("counter did not step on tick"); // [RQ13]

  // Sticky flags and prescale hold until software or power-on writes them
  a_tof_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tof_r && !ctrl_wr) |=> tof_r)
    else $error("timeout flag dropped by itself"); // [RQ4]
  a_rstf_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (rstf_r && !ctrl_wr && !POR_PULSE) |=> rstf_r)
    else $error("reset flag dropped by itself"); // [RQ7]
  a_ps_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!ctrl_wr && !POR_PULSE) |=> $stable(ps_r))
    else $error("prescale changed without write"); // [RQ9]

  // Timer configuration never asks for a device reset
  a_no_req_gpt: assert property (@(posedge CLK_SYS) disable iff (RST)
    gpt |=> !WDT_RESET_REQ)
    else $error("reset request in timer mode"); // [RQ12]

  // One unlock opens one control write only
  a_unlock_once: assert property (@(posedge CLK_SYS) disable iff (RST)
    ctrl_wr |=> !open)
    else $error("unlock stayed open after write"); // [RQ11]

  // Interrupt falls once nothing unmasked is pending
  a_irq_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
    !(|(stat_r & mask_r)) |=> !IRQ)
    else $error("irq without unmasked status");

  c_overflow:  cover property (@(posedge CLK_SYS) ovf);
  c_unlocked:  cover property (@(posedge CLK_SYS) ctrl_wr);
  c_wdt_reset: cover property (@(posedge CLK_SYS) WDT_RESET_REQ);
  c_clearing:  cover property (@(posedge CLK_SYS) clr_r);
  c_lp_tick:   cover property (@(posedge CLK_SYS) LOWPOWER && tick);
endmodule : wdc_top
`default_nettype wire

// >>> testbench/wdc_tb_top.sv
// Self-checking testbench for the watchdog control unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_control_unit_tb_top
  import wdc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic        por_pulse = 1'b1;
  logic        lowpower  = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [9:0]  adr       = 10'h000;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        rst_req;
  logic        irq;
  logic [31:0] q;
  logic [31:0] q2;
  logic        err_seen;
  int          err_total = 0;
  int          checked   = 0;

  wdc_top #(.CNT_W(6)) i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .POR_PULSE(por_pulse),
    .LOWPOWER(lowpower), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .WDT_RESET_REQ(rst_req), .IRQ(irq));

  // 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  // One classic cycle; waits for ack or err, never a fixed count
  task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = rdat;
    err_seen = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Read and compare the masked bits
  task automatic rdc(input logic [9:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    wb(a, 1'b0, 32'h0);
    cmp(q & m, e);
  endtask : rdc

  // Key pair straight before the protected write
  task automatic ctrl_wr(input logic [7:0] d);
    wb(WDC_TA_ADDR, 1'b1, {24'h0, WDC_KEY1});
    wb(WDC_TA_ADDR, 1'b1, {24'h0, WDC_KEY2});
    wb(WDC_CTRL_ADDR, 1'b1, {24'h0, d});
  endtask : ctrl_wr

  task automatic summarize;
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    @(posedge clk_sys);
    por_pulse <= 1'b0;
    repeat (19) @(posedge clk_sys);
    rst <= 1'b0;
    // Power-on values: largest ratio, reset flag clear, timer mode
    rdc(WDC_CTRL_ADDR, 32'h07, 32'hffff_ff8f);
    rdc(WDC_CFG_ADDR, 32'h0f, 32'h0f);
    wb(10'h3fc, 1'b0, 32'h0);
    cmp({31'h0, err_seen}, 32'h1);
    // Unprotected and wrongly ordered writes are ignored
    wb(WDC_CTRL_ADDR, 1'b1, 32'h80);
    rdc(WDC_CTRL_ADDR, 32'h07, 32'hc7);
    wb(WDC_TA_ADDR, 1'b1, {24'h0, WDC_KEY2});
    wb(WDC_TA_ADDR, 1'b1, {24'h0, WDC_KEY1});
    wb(WDC_CTRL_ADDR, 1'b1, 32'h80);
    rdc(WDC_CTRL_ADDR, 32'h07, 32'hc7);
    // Run at 1/1 until the counter wraps
    ctrl_wr(8'h80);
    rdc(WDC_CTRL_ADDR, 32'h80, 32'hc7);
    repeat (100) @(posedge clk_sys);
    rdc(WDC_STAT_ADDR, 32'h1, 32'h1);
    ctrl_wr(8'h20);
    repeat (100) @(posedge clk_sys);
    rdc(WDC_CTRL_ADDR, 32'h20, 32'ha0);
    // Stopped counter holds; zero clear bit leaves it
    wb(WDC_CNT_ADDR, 1'b0, 32'h0);
    q2 = q;
    ctrl_wr(8'h00);
    rdc(WDC_CTRL_ADDR, 32'h00, 32'h20);
    rdc(WDC_CNT_ADDR, q2, 32'hffff_ffff);
    ctrl_wr(8'h40);
    rdc(WDC_CNT_ADDR, 32'h0, 32'hffff_ffff);
    rdc(WDC_CTRL_ADDR, 32'h0, 32'h40);
    // Interrupt: mask, raise, clear
    wb(WDC_MASK_ADDR, 1'b1, 32'h0);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, irq}, 32'h0);
    wb(WDC_MASK_ADDR, 1'b1, 32'h1);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, irq}, 32'h1);
    wb(WDC_STAT_ADDR, 1'b1, 32'h1);
    repeat (3) @(posedge clk_sys);
    cmp({31'h0, irq}, 32'h0);
    rdc(WDC_STAT_ADDR, 32'h0, 32'h1);
    // Low power: stop unless the low-power-run bit is set
    // Low power is left by the level, never by a watchdog reset
    lowpower <= 1'b1;
    ctrl_wr(8'h80);
    wb(WDC_CNT_ADDR, 1'b0, 32'h0);
    q2 = q;
    rdc(WDC_CNT_ADDR, q2, 32'hffff_ffff);
    ctrl_wr(8'h90);
    wb(WDC_CNT_ADDR, 1'b0, 32'h0);
    q2 = q;
    wb(WDC_CNT_ADDR, 1'b0, 32'h0);
    cmp({31'h0, q !== q2}, 32'h1);
    lowpower <= 1'b0;
    // Reset configuration: overflow asks for a device reset
    wb(WDC_CFG_ADDR, 1'b1, 32'h5);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rst_req !== 1'b1 && n < 300);
    cmp({31'h0, rst_req}, 32'h1);
    rdc(WDC_CTRL_ADDR, 32'h08, 32'h08);
    rdc(WDC_STAT_ADDR, 32'h2, 32'h2);
    // Other reset keeps flag and ratio; power-on restores both
    ctrl_wr(8'h0b); // keep the flag set, ratio 3
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(WDC_CTRL_ADDR, 32'h0b, 32'h0f);
    @(posedge clk_sys);
    por_pulse <= 1'b1;
    @(posedge clk_sys);
    por_pulse <= 1'b0;
    rdc(WDC_CTRL_ADDR, 32'h07, 32'h0f);
    rdc(WDC_CFG_ADDR, 32'h0f, 32'h0f);
    summarize();
  end
endmodule : watchdog_control_unit_tb_top
`default_nettype wire
